// file: compare_output_mode_control.sv
// Compare output-mode control for channels A and B with an AHB-Lite port.
//
// How it works
// - Nonzero A mode hands pin to A output.
// - Nonzero B mode hands pin to B output outside six-output mode.
// - A complement pin only PWM: mode 01, or any nonzero mode in six-output.
// - B complement pin only PWM, mode 01; in six-output, any nonzero A mode.
// - A non-PWM: toggle, clear, set on match.
// - A fast PWM: clear match, set bottom.
// - A dual-slope: clear up-match, set down-match.
// - Six-output single-slope: A waveform drives all pins.
// - Six-output dual-slope: A waveform drives all pins.
// - B non-PWM: toggle, clear, set on match.
// - B fast PWM: clear match, set bottom.
// - B dual-slope: clear up-match, set down-match.
// - A force works only without A PWM.
// - A force acts like a compare match.
// - Force uses mode written same cycle.
// - Force never raises the match flag.
// - A force bit always reads zero.
// - PWM enable bits select PWM per channel.
// - B force behaves like A force.
`include "compare_output_map.svh"

module compare_output_mode_control (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic waveformSelectLo,
  input wire logic waveformSelectHi,
  input wire logic chanAMatch,
  input wire logic chanBMatch,
  input wire logic counterBottom,
  input wire logic countDown,
  output logic chanAOutPin,
  output logic chanAOutPinCompl,
  output logic chanAPinEnable,
  output logic chanAComplEnable,
  output logic chanBOutPin,
  output logic chanBOutPinCompl,
  output logic chanBPinEnable,
  output logic chanBComplEnable,
  output logic sixOutputActive,
  output logic chanAMatchFlag,
  output logic chanBMatchFlag
);

  compare_output_pkg::out_mode_t modeA_q;
  compare_output_pkg::out_mode_t modeB_q;
  compare_output_pkg::out_mode_t modeAEff;
  compare_output_pkg::out_mode_t modeBEff;
  compare_output_pkg::pwm_shape_t shapeA;
  compare_output_pkg::pwm_shape_t shapeB;
  logic pwmA_q;
  logic pwmB_q;
  logic pwmAEff;
  logic pwmBEff;
  logic sixEff;
  logic wrPend_q;
  logic [31:0] wrAddr_q;
  logic addrPhase;
  logic ctlWrite;
  logic forceA;
  logic forceB;
  logic waveDA;
  logic waveDB;
  logic waveA;
  logic waveB;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic outA_q;
  logic outACompl_q;
  logic pinEnA_q;
  logic complEnA_q;
  logic outB_q;
  logic outBCompl_q;
  logic pinEnB_q;
  logic complEnB_q;
  logic six_q;
  logic flagA_q;
  logic flagB_q;

  // Bus decode. The slave never inserts wait states.
  assign addrPhase = hsel && htrans[1] && hready;
  assign ctlWrite = wrPend_q && (wrAddr_q == `OFS_CTL_A);

  // The mode that the waveform logic sees is the one being written this
  // cycle, so a force in the same write uses the new setting.
  assign modeAEff = ctlWrite ?
    hwdata[`CTLA_MODE_A_HI:`CTLA_MODE_A_LO] : modeA_q;
  assign modeBEff = ctlWrite ?
    hwdata[`CTLA_MODE_B_HI:`CTLA_MODE_B_LO] : modeB_q;
  assign pwmAEff = ctlWrite ? hwdata[`CTLA_PWM_A] : pwmA_q;
  assign pwmBEff = ctlWrite ? hwdata[`CTLA_PWM_B] : pwmB_q;

  // Force strobes are pulses only; they never reach a register.
  assign forceA = ctlWrite && hwdata[`CTLA_FORCE_A] && !pwmAEff;
  assign forceB = ctlWrite && hwdata[`CTLA_FORCE_B] && !pwmBEff;

  // Channel B has no six-output shapes, so it only looks at the low select.
  assign shapeA = compare_output_pkg::decode_shape(waveformSelectHi,
    waveformSelectLo);
  assign shapeB = compare_output_pkg::decode_shape(1'b0, waveformSelectLo);
  assign sixEff = pwmAEff && compare_output_pkg::is_six(shapeA);

  function automatic logic [31:0] read_word(input logic [31:0] addr);
    logic [31:0] word;
    word = 32'h0000_0000;
    if (addr == `OFS_CTL_A) begin
      word[`CTLA_MODE_A_HI:`CTLA_MODE_A_LO] = modeA_q;
      word[`CTLA_MODE_B_HI:`CTLA_MODE_B_LO] = modeB_q;
      word[`CTLA_FORCE_A] = 1'b0;
      word[`CTLA_FORCE_B] = 1'b0;
      word[`CTLA_PWM_A] = pwmA_q;
      word[`CTLA_PWM_B] = pwmB_q;
    end else if (addr == `OFS_STATUS) begin
      word[`STAT_WAVE_A] = waveA;
      word[`STAT_WAVE_B] = waveB;
      word[`STAT_PIN_EN_A] = pinEnA_q;
      word[`STAT_COMPL_EN_A] = complEnA_q;
      word[`STAT_PIN_EN_B] = pinEnB_q;
      word[`STAT_COMPL_EN_B] = complEnB_q;
      word[`STAT_SIX_ACTIVE] = six_q;
      word[`STAT_SEL_LO] = waveformSelectLo;
      word[`STAT_SEL_HI] = waveformSelectHi;
    end
    read_word = word;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 32'h0000_0000;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= addrPhase ? haddr : wrAddr_q;
    end
  end

  // Read data is fetched in the address phase and stands in the data phase.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end else begin
      hrdata_q <= (addrPhase && !hwrite) ? read_word(haddr) : 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      modeA_q <= 2'(`CTLA_RESET >> `CTLA_MODE_A_LO);
      modeB_q <= compare_output_pkg::MODE_OFF;
      pwmA_q <= 1'(`CTLA_RESET >> `CTLA_PWM_A);
      pwmB_q <= 1'b0;
    end else begin
      modeA_q <= modeAEff;
      modeB_q <= modeBEff;
      pwmA_q <= pwmAEff;
      pwmB_q <= pwmBEff;
    end
  end

  chan_waveform chanA (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pwmEnable(pwmAEff),
    .shape(shapeA),
    .mode(modeAEff),
    .match(chanAMatch),
    .bottom(counterBottom),
    .countDown(countDown),
    .forceHit(forceA),
    .waveD(waveDA),
    .waveform(waveA)
  );

  chan_waveform chanB (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pwmEnable(pwmBEff),
    .shape(shapeB),
    .mode(modeBEff),
    .match(chanBMatch),
    .bottom(counterBottom),
    .countDown(countDown),
    .forceHit(forceB),
    .waveD(waveDB),
    .waveform(waveB)
  );

  // Pin enables only claim the pin; the port direction bit outside still
  // gates the driver.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pinEnA_q <= 1'b0;
      complEnA_q <= 1'b0;
      pinEnB_q <= 1'b0;
      complEnB_q <= 1'b0;
      six_q <= 1'b0;
    end else begin
      six_q <= sixEff;
      pinEnA_q <= modeAEff != compare_output_pkg::MODE_OFF;
      complEnA_q <= pwmAEff && (sixEff ?
        modeAEff != compare_output_pkg::MODE_OFF :
        modeAEff == compare_output_pkg::MODE_TOGGLE);
      if (sixEff) begin
        pinEnB_q <= modeAEff != compare_output_pkg::MODE_OFF;
        complEnB_q <= modeAEff != compare_output_pkg::MODE_OFF;
      end else begin
        pinEnB_q <= modeBEff != compare_output_pkg::MODE_OFF;
        complEnB_q <= pwmBEff &&
          modeBEff == compare_output_pkg::MODE_TOGGLE;
      end
    end
  end

  // Pins load from the next waveform value so they change on the same edge
  // as the waveform itself.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      outA_q <= 1'b0;
      outACompl_q <= 1'b1;
      outB_q <= 1'b0;
      outBCompl_q <= 1'b1;
    end else begin
      outA_q <= waveDA;
      outACompl_q <= !waveDA;
      outB_q <= sixEff ? waveDA : waveDB;
      outBCompl_q <= sixEff ? !waveDA : !waveDB;
    end
  end

  // Match flags follow real matches only; a forced compare is not a match.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flagA_q <= 1'b0;
      flagB_q <= 1'b0;
    end else begin
      flagA_q <= chanAMatch;
      flagB_q <= chanBMatch;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign chanAOutPin = outA_q;
  assign chanAOutPinCompl = outACompl_q;
  assign chanAPinEnable = pinEnA_q;
  assign chanAComplEnable = complEnA_q;
  assign chanBOutPin = outB_q;
  assign chanBOutPinCompl = outBCompl_q;
  assign chanBPinEnable = pinEnB_q;
  assign chanBComplEnable = complEnB_q;
  assign sixOutputActive = six_q;
  assign chanAMatchFlag = flagA_q;
  assign chanBMatchFlag = flagB_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  property p_pin_a;
    modeA_q != compare_output_pkg::MODE_OFF |-> chanAPinEnable;
  endproperty
  a_pin_a: assert property (p_pin_a)
    else $error("Channel A pin not taken over.");

  property p_pin_b;
    (!six_q && modeB_q == compare_output_pkg::MODE_OFF) |-> !chanBPinEnable;
  endproperty
  a_pin_b: assert property (p_pin_b)
    else $error("Channel B pin taken with mode off.");

  property p_compl_a;
    (chanAComplEnable && !six_q) |->
      pwmA_q && modeA_q == compare_output_pkg::MODE_TOGGLE;
  endproperty
  a_compl_a: assert property (p_compl_a)
    else $error("Channel A complement connected wrongly.");

  property p_compl_b;
    (!six_q && pwmB_q && modeB_q == compare_output_pkg::MODE_TOGGLE)
      |-> chanBComplEnable;
  endproperty
  a_compl_b: assert property (p_compl_b)
    else $error("Channel B complement not connected.");

  property p_toggle_a;
    (!ctlWrite && !pwmA_q && modeA_q == compare_output_pkg::MODE_TOGGLE &&
      chanAMatch) |=> chanAOutPin != $past(chanAOutPin);
  endproperty
  a_toggle_a: assert property (p_toggle_a)
    else $error("Channel A did not toggle on match.");

  property p_fast_a;
    (!ctlWrite && pwmA_q && shapeA == compare_output_pkg::SHAPE_FAST &&
      modeA_q == compare_output_pkg::MODE_CLEAR && counterBottom &&
      !chanAMatch) ##1 (!ctlWrite && chanAMatch) |=> !chanAOutPin;
  endproperty
  a_fast_a: assert property (p_fast_a)
    else $error("Channel A fast PWM sequence wrong.");

  property p_pfc_b;
    (!ctlWrite && pwmB_q && waveformSelectLo && !sixEff &&
      modeB_q == compare_output_pkg::MODE_SET && chanBMatch)
      |=> chanBOutPin == !$past(countDown);
  endproperty
  a_pfc_b: assert property (p_pfc_b)
    else $error("Channel B dual-slope action wrong.");

  property p_six;
    six_q |-> chanBOutPin == chanAOutPin &&
      chanBOutPinCompl == chanAOutPinCompl;
  endproperty
  a_six: assert property (p_six)
    else $error("Six-output pins differ from channel A.");

  property p_force;
    (ctlWrite && hwdata[`CTLA_FORCE_A] && !hwdata[`CTLA_PWM_A] &&
      hwdata[`CTLA_MODE_A_HI:`CTLA_MODE_A_LO] == compare_output_pkg::MODE_SET)
      |=> chanAOutPin ##1 chanAOutPin || !chanAMatch;
  endproperty
  a_force: assert property (p_force)
    else $error("Forced compare did not set channel A.");

  property p_no_flag;
    chanAMatchFlag |-> $past(chanAMatch);
  endproperty
  a_no_flag: assert property (p_no_flag)
    else $error("Match flag raised without a match.");

  property p_read_zero;
    (addrPhase && !hwrite && haddr == `OFS_CTL_A) |=>
      hrdata[`CTLA_FORCE_A:`CTLA_FORCE_B] == 2'h0 && hreadyout;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("Force bits did not read as zero.");

  c_force: cover property (forceA ##1 chanAOutPin);
  c_fast: cover property (pwmA_q && counterBottom ##[1:20] chanAMatch);
  c_six: cover property (six_q && chanBComplEnable);
  c_pfc: cover property (pwmB_q && chanBMatch && countDown);

endmodule

// file: compare_output_map.svh
// Register offsets, field positions and reset values of the output-mode block.
`ifndef COMPARE_OUTPUT_MAP_SVH
`define COMPARE_OUTPUT_MAP_SVH

// Byte offsets on the register bus.
`define OFS_CTL_A 32'h0000_0000
`define OFS_STATUS 32'h0000_0004

// Field positions in compare_output_control_a.
`define CTLA_MODE_A_HI 7
`define CTLA_MODE_A_LO 6
`define CTLA_MODE_B_HI 5
`define CTLA_MODE_B_LO 4
`define CTLA_FORCE_A 3
`define CTLA_FORCE_B 2
`define CTLA_PWM_A 1
`define CTLA_PWM_B 0
`define CTLA_RESET 8'h00

// Field positions in the status register.
`define STAT_WAVE_A 0
`define STAT_WAVE_B 1
`define STAT_PIN_EN_A 2
`define STAT_COMPL_EN_A 3
`define STAT_PIN_EN_B 4
`define STAT_COMPL_EN_B 5
`define STAT_SIX_ACTIVE 6
`define STAT_SEL_LO 7
`define STAT_SEL_HI 8

`endif

// file: compare_output_pkg.sv
// Types and decode helpers shared by the output-mode block.
package compare_output_pkg;

  typedef logic [1:0] out_mode_t;

  localparam out_mode_t MODE_OFF = 2'h0;
  localparam out_mode_t MODE_TOGGLE = 2'h1;
  localparam out_mode_t MODE_CLEAR = 2'h2;
  localparam out_mode_t MODE_SET = 2'h3;

  typedef enum logic [3:0] {
    SHAPE_FAST = 4'h1,
    SHAPE_PFC = 4'h2,
    SHAPE_SIX_SINGLE = 4'h4,
    SHAPE_SIX_DUAL = 4'h8
  } pwm_shape_t;

  function automatic pwm_shape_t decode_shape(input logic hi, input logic lo);
    case ({hi, lo})
      2'h0: decode_shape = SHAPE_FAST;
      2'h1: decode_shape = SHAPE_PFC;
      2'h2: decode_shape = SHAPE_SIX_SINGLE;
      default: decode_shape = SHAPE_SIX_DUAL;
    endcase
  endfunction

  function automatic logic is_six(input pwm_shape_t shape);
    is_six = (shape == SHAPE_SIX_SINGLE) || (shape == SHAPE_SIX_DUAL);
  endfunction

endpackage

// file: chan_waveform.sv
// One compare channel's waveform register and its mode-dependent update.
module chan_waveform (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic pwmEnable,
  input compare_output_pkg::pwm_shape_t shape,
  input compare_output_pkg::out_mode_t mode,
  input wire logic match,
  input wire logic bottom,
  input wire logic countDown,
  input wire logic forceHit,
  output logic waveD,
  output logic waveform
);

  logic wave_q;
  logic inverted;

  assign inverted = (mode == compare_output_pkg::MODE_SET);

  // Match wins over bottom when both come in one cycle, so a compare value
  // of zero still yields the match action.
  always_comb begin
    waveD = wave_q;
    if (mode != compare_output_pkg::MODE_OFF) begin
      if (!pwmEnable) begin
        if (match || forceHit) begin
          case (mode)
            compare_output_pkg::MODE_TOGGLE: waveD = !wave_q;
            compare_output_pkg::MODE_CLEAR: waveD = 1'b0;
            default: waveD = 1'b1;
          endcase
        end
      end else if (shape == compare_output_pkg::SHAPE_FAST ||
                   shape == compare_output_pkg::SHAPE_SIX_SINGLE) begin
        if (bottom) begin
          waveD = !inverted;
        end
        if (match) begin
          waveD = inverted;
        end
      end else if (match) begin
        waveD = inverted ^ countDown;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= waveD;
    end
  end

  assign waveform = wave_q;

endmodule

// file: compare_output_mode_control_tb_top.sv
// Self-checking testbench for the compare output-mode block.
`include "compare_output_map.svh"

module compare_output_mode_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rstn, hsel, hwrite, selLo, selHi;
  logic matchA, matchB, bottom, down, pwmA, pwmB, expA, expB;
  logic pmA, pmB, pb, pd;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  wire logic [12:0] act;
  logic [12:0] e;
  compare_output_pkg::out_mode_t modeA, modeB;
  int n_errors, checked;

  compare_output_mode_control uut (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(act[11]), .hrdata(hrdata), .hreadyout(act[11]),
    .hresp(act[12]), .waveformSelectLo(selLo), .waveformSelectHi(selHi),
    .chanAMatch(matchA), .chanBMatch(matchB), .counterBottom(bottom),
    .countDown(down), .chanAOutPin(act[0]), .chanAOutPinCompl(act[1]),
    .chanBOutPin(act[2]), .chanBOutPinCompl(act[3]),
    .chanAPinEnable(act[4]), .chanAComplEnable(act[5]),
    .chanBPinEnable(act[6]), .chanBComplEnable(act[7]),
    .sixOutputActive(act[8]), .chanAMatchFlag(act[9]),
    .chanBMatchFlag(act[10])
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Next waveform value; a forced compare is modelled as a non-PWM match.
  function automatic logic nxt(logic w, compare_output_pkg::out_mode_t m,
                               logic pwm, logic dual, logic mt, logic bt,
                               logic dn);
    if (!pwm) begin
      if (!mt) return w;
      case (m)
        2'h1: return ~w;
        2'h2: return 1'b0;
        2'h3: return 1'b1;
        default: return w;
      endcase
    end
    if (m == 2'h0) return w;
    if (dual) return mt ? (dn ^ (m == 2'h3)) : w;
    if (mt) return m == 2'h3;
    if (bt) return m != 2'h3;
    return w;
  endfunction

  function automatic logic [12:0] exp_vec();
    logic s, eA, wB;
    s = pwmA & selHi;
    eA = modeA != 2'h0;
    wB = s ? expA : expB;
    return {1'b0, 1'b1, pmB, pmA, s,
            s ? eA : pwmB & (modeB == 2'h1), s ? eA : modeB != 2'h0,
            s ? eA : pwmA & (modeA == 2'h1), eA, ~wB, wB, ~expA, expA};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d of %0d comparisons", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic bus_write(input logic [31:0] a, d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b1;
    do @(posedge sys_clk); while (act[11] !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (act[11] !== 1'b1);
  endtask

  task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b0;
    do @(posedge sys_clk); while (act[11] !== 1'b1);
    htrans <= 2'h0;
    do @(posedge sys_clk); while (act[11] !== 1'b1);
    d = hrdata;
  endtask

  // The model absorbs the inputs sampled at this edge, then drives new ones.
  task automatic step(input logic mA, mB, bt, dn);
    @(posedge sys_clk);
    expA = nxt(expA, modeA, pwmA, selLo, pmA, pb, pd);
    expB = nxt(expB, modeB, pwmB, selLo, pmB, pb, pd);
    e = exp_vec();
    matchA <= mA;
    matchB <= mB;
    bottom <= bt;
    down <= dn;
    {pmA, pmB, pb, pd} = {mA, mB, bt, dn};
    @(negedge sys_clk);
    check("wvA", 32'(act[1:0]), 32'(e[1:0]));
    check("wvB", 32'(act[3:2]), 32'(e[3:2]));
    check("pinA", 32'(act[5:4]), 32'(e[5:4]));
    check("pinB", 32'(act[7:6]), 32'(e[7:6]));
    check("six", 32'(act[8]), 32'(e[8]));
    check("flag", 32'(act[12:9]), 32'(e[12:9]));
  endtask

  // Timer inputs are idle during the write so only the force can act.
  task automatic set_ctrl(input logic [7:0] v, input logic [1:0] s);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge sys_clk);
    selLo <= s[0];
    selHi <= s[1];
    modeA = v[7:6];
    modeB = v[5:4];
    pwmA = v[1];
    pwmB = v[0];
    bus_write(`OFS_CTL_A, {24'h0000_00, v});
    if (v[3] && !pwmA) begin
      expA = nxt(expA, modeA, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    end
    if (v[2] && !pwmB) begin
      expB = nxt(expB, modeB, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    end
    @(negedge sys_clk);
    check("force flag", 32'(act[10:9]), 32'h0000_0000);
    bus_read(`OFS_CTL_A, rd);
    check("ctrl", rd, {24'h0000_00, v & 8'hf3});
  endtask

  initial begin
    #500000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    {rstn, hsel, hwrite, selLo, selHi, matchA, matchB, bottom, down} = '0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    {modeA, modeB, pwmA, pwmB, expA, expB, pmA, pmB, pb, pd} = '0;
    n_errors = 0;
    checked = 0;
    rd = $urandom(32'h26de_ac5b);
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    e = exp_vec();
    check("reset outputs", 32'(act), 32'(e));
    @(posedge sys_clk);
    rstn <= 1'b1;
    bus_read(`OFS_CTL_A, rd);
    check("ctrl reset", rd, 32'h0000_0000);
    // Back-to-back forced toggles, a forced set, then a force under PWM.
    set_ctrl(8'h48, 2'h0);
    set_ctrl(8'h48, 2'h0);
    set_ctrl(8'hc8, 2'h0);
    set_ctrl(8'h4a, 2'h0);
    bus_write(32'h0000_0010, 32'h0000_00ff);
    bus_read(`OFS_CTL_A, rd);
    check("unmapped write", rd, 32'h0000_0042);
    bus_read(32'h0000_0008, rd);
    check("unmapped read", rd, 32'h0000_0000);
    for (int i = 0; i < 80; i++) begin
      set_ctrl(8'($urandom), 2'($urandom));
      repeat (16) begin
        step($urandom % 4 == 0, $urandom % 4 == 0, $urandom % 8 == 0,
             1'($urandom));
      end
      step(1'b0, 1'b0, 1'b0, 1'b0);
      bus_read(`OFS_STATUS, rd);
      check("status", rd, {23'h00_0000, selHi, selLo, e[8:4], expB,
                          expA});
    end
    tally_and_finish();
  end
endmodule
